// [arpwm_cfg.svh]
// Constants of the dual autoreload PWM timer: offsets, fields, resets, widths.
// Assumes byte-wide registers reached over the plain strobe port.
`ifndef ARPWM_CFG_SVH
`define ARPWM_CFG_SVH

// Register offsets (5-bit index)
`define OFS_CTRL        5'h00
`define OFS_RELOAD1_L   5'h01
`define OFS_RELOAD1_H   5'h02
`define OFS_RELOAD2_L   5'h03
`define OFS_RELOAD2_H   5'h04
`define OFS_DUTY_BASE   5'h05
`define OFS_OUTCTL      5'h0D
`define OFS_DEADTIME    5'h0E
`define OFS_BRKCTL      5'h0F
`define OFS_BRKEN       5'h10
`define OFS_STATUS      5'h11
`define OFS_CAP_L       5'h12
`define OFS_CAP_H       5'h13

// Control register fields
`define CTRL_ENC2       0
`define CTRL_TRANSFER_ONE_ENABLE      1
`define CTRL_TRANSFER_TWO_ENABLE      2
`define CTRL_COMPARE_IRQ_ENABLE      3
`define CTRL_CAPTURE_IRQ_ENABLE       4
`define CTRL_RESET      8'h06

// Break control fields
`define BRK_ACTIVE      7
`define BRK_FUNC_EN     6
`define BRK_LEVEL       5
`define BRK_SRC         4

// Timing figures
`define CNT_MAX         12'hFFF
`define DT_BITS         7
`define DT_ENABLE_BIT   7

`endif

// [arpwm_pkg.sv]
// Types shared by the timer files.
// Assumes arpwm_cfg.svh is compiled with it.
package arpwm_pkg;

    // Register bus request
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_t;

    // Deadtime phase of channel 0/1 pair
    typedef enum logic [1:0] {
        DT_IDLE  = 2'b00,
        DT_WAIT0 = 2'b01,
        DT_WAIT1 = 2'b10
    } dt_state_t;

    // State of one counter channel
    typedef struct packed {
        logic [11:0] cnt;
        logic [11:0] reload;
    } counter_t;

endpackage : arpwm_pkg

// [pwm_channel.sv]
// One PWM channel: preload/active duty, polarity latch, compare.
// Assumes the parent supplies the counter, its overflow and the transfer bit.
`timescale 1ns/10ps
`default_nettype none
`include "arpwm_cfg.svh"
module pwm_channel
    import arpwm_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        clearAll,    // Break clears duty registers
    input  wire logic        dutyWr,      // Write to preload duty
    input  wire logic        dutyHigh,    // Selects high nibble
    input  wire logic [7:0]  wdata,
    input  wire logic [11:0] count,
    input  wire logic        ovf,
    input  wire logic        transfer,
    input  wire logic        polarityIn,
    output logic      [11:0] preload,
    output logic      [11:0] active,
    output logic             wave,        // Raw PWM, before polarity
    output logic             polarity,    // Polarity latched at overflow
    output logic             match        // Compare hit, nonzero duty only
);
    typedef struct packed {
        logic [11:0] pre;
        logic [11:0] act;
        logic        wave;
        logic        pol;
    } chan_t;

    chan_t st_r;
    chan_t st_nxt;

    // Next state of the channel
    always_comb
    begin
        st_nxt = st_r;
        if (dutyWr)
        begin
            if (dutyHigh)
                st_nxt.pre[11:8] = wdata[3:0];
            else
                st_nxt.pre[7:0] = wdata;
        end
        if (ovf)
        begin
            st_nxt.wave = 1'b1;
            if (transfer)
            begin
                st_nxt.act = st_r.pre;
                st_nxt.pol = polarityIn;
            end
        end
        else if (count == st_r.act)
            st_nxt.wave = 1'b0;
        if (clearAll)
        begin
            st_nxt.pre  = 12'h000;
            st_nxt.act  = 12'h000;
            st_nxt.wave = 1'b0;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign preload  = st_r.pre;
    assign active   = st_r.act;
    assign wave     = st_r.wave;
    assign polarity = st_r.pol;
    // Zero duty never flags a compare
    assign match    = (st_r.act != 12'h000) && (count == st_r.act);

endmodule : pwm_channel
`default_nettype wire

// [arpwm_timer.sv]
// Dual 12-bit autoreload PWM timer with dead time, break, compare, capture.
// Assumes synchronous pins at ref_clk and a one-cycle strobe register port.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "arpwm_cfg.svh"
module arpwm_timer
    import arpwm_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [4:0] addr,         // Register index
    input  wire logic [7:0] wdata,        // Write data
    input  wire logic       wr,           // Write strobe
    input  wire logic       rd,           // Read strobe
    output logic      [7:0] rdata,        // Read data, cycle after rd
    input  wire logic       brkPin,       // Break input
    input  wire logic       captureInput, // Capture input
    output logic      [3:0] waveOut,      // PWM pin levels
    output logic      [3:0] waveOutEn,    // High while timer drives pin
    output logic            compareIrq,   // Compare request
    output logic            captureIrq    // Capture request
);
    // Register state of the timer, apart from the channel duty registers
    typedef struct packed {
        counter_t    c1;
        counter_t    c2;
        logic [7:0]  ctrl;
        logic [7:0]  outctl;        // [3:0] enables, [7:4] polarity bits
        logic [7:0]  dtWrite;       // Software copy of dead-time byte
        logic [7:0]  dtActive;      // Buffered copy used by the logic
        logic [7:0]  brkctl;        // Flag, enable, level, source, pattern
        logic [1:0]  brkEn;
        logic [3:0]  cmpFlag;
        logic        capFlag;
        logic [11:0] capValue;
        logic [2:0]  brkSync;
        logic [2:0]  capSync;
        dt_state_t   dtState;
        logic [6:0]  dtCount;
        logic [1:0]  dtOut;          // Dead-time shaped out0/out1
        logic [7:0]  rdata;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [11:0] chCount [4];   // Counter feeding each channel
    logic [3:0]  chOvf;         // Overflow seen by each channel
    logic [3:0]  chTran;        // Transfer bit of each channel
    logic [3:0]  chWave;
    logic [3:0]  chPol;
    logic [3:0]  chMatch;
    logic [11:0] chPre [4];
    logic [11:0] chAct [4];
    logic        dualMode;
    logic        ovf1;
    logic        ovf2;
    logic        brkStop1;      // Break applies to counter one
    logic        brkStop2;      // Break applies to counter two
    logic [3:0]  brkMask;       // Outputs under break
    logic [3:0]  dutyWr;
    logic        brkLevelHit;
    logic        capEdge;
    logic [3:0]  rawWave;

    // Dual mode hands outputs 2 and 3 over to counter two
    assign dualMode = st_r.ctrl[`CTRL_ENC2];
    // Overflow at the all-ones count
    assign ovf1 = (st_r.c1.cnt == `CNT_MAX);
    assign ovf2 = dualMode && (st_r.c2.cnt == `CNT_MAX);
    // Per-counter break gating depends on mode
    assign brkStop1 = st_r.brkctl[`BRK_ACTIVE] && st_r.brkEn[0];
    assign brkStop2 = st_r.brkctl[`BRK_ACTIVE] &&
                      (dualMode ? st_r.brkEn[1] : st_r.brkEn[0]);
    assign brkMask  = {brkStop2, brkStop2, brkStop1, brkStop1};
    // Second sync stage feeds the detectors only
    assign brkLevelHit = (st_r.brkSync[1] == st_r.brkctl[`BRK_LEVEL]);
    assign capEdge     = st_r.capSync[1] ^ st_r.capSync[2];

    // Channel routing between counters
    always_comb
    begin
        chCount[0] = st_r.c1.cnt;
        chCount[1] = st_r.c1.cnt;
        chCount[2] = dualMode ? st_r.c2.cnt : st_r.c1.cnt;
        chCount[3] = dualMode ? st_r.c2.cnt : st_r.c1.cnt;
        chOvf      = dualMode ? {ovf2, ovf2, ovf1, ovf1} : {4{ovf1}};
        chTran     = dualMode ?
                     {{2{st_r.ctrl[`CTRL_TRANSFER_TWO_ENABLE]}}, {2{st_r.ctrl[`CTRL_TRANSFER_ONE_ENABLE]}}} :
                     {4{st_r.ctrl[`CTRL_TRANSFER_ONE_ENABLE]}};
        // Duty pairs start at an odd index: high nibble first, then low byte
        // Writes are refused while the channel's counter sits in break
        for (int i = 0; i < 4; i++)
            dutyWr[i] = wr && !brkMask[i] &&
                        (addr == `OFS_DUTY_BASE + 5'(2 * i) ||
                         addr == `OFS_DUTY_BASE + 5'(2 * i + 1));
    end

    // Four identical channels
    for (genvar g = 0; g < 4; g++)
    begin : gChan
        pwm_channel uChan (
            .ref_clk    (ref_clk),
            .resetn     (resetn),
            .clearAll   (brkMask[g]),
            .dutyWr     (dutyWr[g]),
            .dutyHigh   (addr == `OFS_DUTY_BASE + 5'(2 * g)),
            .wdata      (wdata),
            .count      (chCount[g]),
            .ovf        (chOvf[g] && !brkMask[g]),
            .transfer   (chTran[g]),
            .polarityIn (st_r.outctl[4 + g]),
            .preload    (chPre[g]),
            .active     (chAct[g]),
            .wave       (chWave[g]),
            .polarity   (chPol[g]),
            .match      (chMatch[g])
        );
    end

    // Main next-state logic
    always_comb
    begin
        st_nxt = st_r;
        // Synchroniser shift registers
        st_nxt.brkSync = {st_r.brkSync[1:0], brkPin};
        st_nxt.capSync = {st_r.capSync[1:0], captureInput};

        // Counter one: reload after overflow, stop under break
        // Break holds the count at zero until software clears the flag
        if (brkStop1)
            st_nxt.c1 = '0;
        else if (ovf1)
            st_nxt.c1.cnt = st_r.c1.reload;
        else
            st_nxt.c1.cnt = st_r.c1.cnt + 12'h001;
        // Counter two runs only in dual mode
        // Single mode leaves counter two parked where it stood unless a break on counter one zeroes it
        if (brkStop2)
            st_nxt.c2 = '0;
        else if (ovf2)
            st_nxt.c2.cnt = st_r.c2.reload;
        else if (dualMode)
            st_nxt.c2.cnt = st_r.c2.cnt + 12'h001;

        // Dead-time byte takes effect only at an overflow
        // The gap loaded at that same overflow still uses the old byte,
        // so a new byte shapes the out1 gap of the cycle in which it lands, and the out0 gap only from the next cycle
        if (ovf1)
            st_nxt.dtActive = st_r.dtWrite;

        // Dead-time shaping of outputs 0 and 1
        case (st_r.dtState)
            DT_IDLE:
            begin
                if (ovf1)
                begin
                    st_nxt.dtOut   = 2'b00;
                    st_nxt.dtCount = st_r.dtActive[6:0];
                    st_nxt.dtState = DT_WAIT0;
                end
                else if (st_r.c1.cnt == chAct[0] && st_r.dtOut[0])
                begin
                    st_nxt.dtOut   = 2'b00;
                    st_nxt.dtCount = st_r.dtActive[6:0];
                    st_nxt.dtState = DT_WAIT1;
                end
            end
            // Out0 rises once the gap has run out
            DT_WAIT0:
            begin
                if (st_r.dtCount <= 7'h01)
                begin
                    st_nxt.dtOut[0] = 1'b1;
                    st_nxt.dtState  = DT_IDLE;
                end
                else
                    st_nxt.dtCount = st_r.dtCount - 7'h01;
            end
            // Reload cuts the out1 wait short and starts the out0 gap
            DT_WAIT1:
            begin
                if (ovf1)
                begin
                    st_nxt.dtOut   = 2'b00;
                    st_nxt.dtCount = st_r.dtActive[6:0];
                    st_nxt.dtState = DT_WAIT0;
                end
                else if (st_r.dtCount <= 7'h01)
                begin
                    st_nxt.dtOut[1] = 1'b1;
                    st_nxt.dtState  = DT_IDLE;
                end
                else
                    st_nxt.dtCount = st_r.dtCount - 7'h01;
            end
            default:
                st_nxt.dtState = DT_IDLE;
        endcase
        // Break parks the shaper so both halves start low on release
        if (brkStop1)
        begin
            st_nxt.dtState = DT_IDLE;
            st_nxt.dtOut   = 2'b00;
        end

        // Compare flags: set wins over clear
        // A channel in break flags only via a status write that meets its match in the first break cycle; after that its duty is zero
        for (int i = 0; i < 4; i++)
            if (chMatch[i] && !brkMask[i])
                st_nxt.cmpFlag[i] = 1'b1;

        // Capture of counter one, blocked while flag is set
        // An edge in the cycle of the clearing read is lost: the flag still blocks it
        if (rd && st_r.capFlag && (addr == `OFS_CAP_L || addr == `OFS_CAP_H))
            st_nxt.capFlag = 1'b0;
        if (capEdge && !st_r.capFlag)
        begin
            st_nxt.capValue = st_r.c1.cnt;
            st_nxt.capFlag  = 1'b1;
        end

        // Register writes
        // Reload writes are dropped while that counter is held in break
        if (wr)
        begin
            case (addr)
                `OFS_CTRL:      st_nxt.ctrl = wdata;
                `OFS_RELOAD1_L: if (!brkStop1) st_nxt.c1.reload[7:0] = wdata;
                `OFS_RELOAD1_H: if (!brkStop1) st_nxt.c1.reload[11:8] = wdata[3:0];
                `OFS_RELOAD2_L: if (!brkStop2) st_nxt.c2.reload[7:0] = wdata;
                `OFS_RELOAD2_H: if (!brkStop2) st_nxt.c2.reload[11:8] = wdata[3:0];
                `OFS_OUTCTL:    st_nxt.outctl = wdata;
                `OFS_DEADTIME:  st_nxt.dtWrite = wdata;
                `OFS_BRKCTL:    st_nxt.brkctl = wdata;
                `OFS_BRKEN:     st_nxt.brkEn = wdata[1:0];
                `OFS_STATUS:    st_nxt.cmpFlag = st_r.cmpFlag & ~wdata[3:0] | chMatch;
                default:        st_nxt.rdata = st_r.rdata;
            endcase
        end
        // Pin break sets the flag; set wins over software clear
        // A pin held at its active level raises the flag again after a clear
        if (st_r.brkctl[`BRK_FUNC_EN] && st_r.brkctl[`BRK_SRC] && brkLevelHit)
            st_nxt.brkctl[`BRK_ACTIVE] = 1'b1;

        // Read data, valid in the cycle after rd
        // Reads have no side effect beyond the capture-flag clear above
        st_nxt.rdata = 8'h00;
        if (rd)
        begin
            case (addr)
                `OFS_CTRL:      st_nxt.rdata = st_r.ctrl;
                `OFS_RELOAD1_L: st_nxt.rdata = st_r.c1.reload[7:0];
                `OFS_RELOAD1_H: st_nxt.rdata = {4'h0, st_r.c1.reload[11:8]};
                `OFS_RELOAD2_L: st_nxt.rdata = st_r.c2.reload[7:0];
                `OFS_RELOAD2_H: st_nxt.rdata = {4'h0, st_r.c2.reload[11:8]};
                `OFS_OUTCTL:    st_nxt.rdata = st_r.outctl;
                `OFS_DEADTIME:  st_nxt.rdata = st_r.dtWrite;
                `OFS_BRKCTL:    st_nxt.rdata = st_r.brkctl;
                `OFS_BRKEN:     st_nxt.rdata = {6'h00, st_r.brkEn};
                `OFS_STATUS:    st_nxt.rdata = {3'h0, st_r.capFlag, st_r.cmpFlag};
                `OFS_CAP_L:     st_nxt.rdata = st_r.capValue[7:0];
                `OFS_CAP_H:     st_nxt.rdata = {4'h0, st_r.capValue[11:8]};
                default:
                begin
                    for (int i = 0; i < 4; i++)
                    begin
                        if (addr == `OFS_DUTY_BASE + 5'(2 * i))
                            st_nxt.rdata = {4'h0, chPre[i][11:8]};
                        if (addr == `OFS_DUTY_BASE + 5'(2 * i + 1))
                            st_nxt.rdata = chPre[i][7:0];
                    end
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            // Everything else clears, which starts counter one from 000h and parks counter two there
            st_r      <= '0;
            st_r.ctrl <= `CTRL_RESET;    // Transfer bits reset to set
        end
        else
            st_r <= st_nxt;
    end

    // Output selection: dead time, polarity, break pattern, enable
    // Inverting out0 or out1 undoes the non-overlap that dead time buys
    always_comb
    begin
        rawWave = chWave;
        if (st_r.dtActive[`DT_ENABLE_BIT])
        begin
            if (st_r.dtActive[6:0] == 7'h00)
                rawWave = 4'h0;
            else
                rawWave[1:0] = st_r.dtOut;
        end
        for (int i = 0; i < 4; i++)
        begin
            if (brkMask[i])
                waveOut[i] = st_r.brkctl[i];
            else
                waveOut[i] = rawWave[i] ^ chPol[i];
        end
        waveOutEn = st_r.outctl[3:0];
    end

    // Interrupt requests are levels that drop when the flag is cleared
    assign rdata      = st_r.rdata;
    assign compareIrq = st_r.ctrl[`CTRL_COMPARE_IRQ_ENABLE] && (st_r.cmpFlag != 4'h0);
    assign captureIrq = st_r.ctrl[`CTRL_CAPTURE_IRQ_ENABLE] && st_r.capFlag;

endmodule : arpwm_timer
`default_nettype wire

// [power_stage_model.sv]
// Far side of the timer: a power stage that raises a fault line and a capture signal.
// Assumes its tasks are called just after a rising edge of ref_clk.
`timescale 1ns/10ps
`default_nettype none
module power_stage_model (
    input  wire logic ref_clk,      // Timer clock
    output logic      brkPin,       // Fault line towards the timer
    output logic      captureInput  // Signal whose edges get timed
);
    // Both lines idle low from power-up
    initial
    begin
        brkPin = 1'b0;
        captureInput = 1'b0;
    end

    // Fault line; lag lets the stage answer promptly or slowly
    task automatic trip(input logic lvl, input int lag);
        repeat (lag) @(posedge ref_clk);
        brkPin <= lvl;
    endtask : trip

    // One edge of the timed signal, rising or falling in turn
    task automatic flip_capture(input int lag);
        repeat (lag) @(posedge ref_clk);
        captureInput <= ~captureInput;
    endtask : flip_capture
endmodule : power_stage_model
`default_nettype wire

// [arpwm_timer_sva.sv]
// Checker for the autoreload PWM timer: enables, compare irq mask, capture flag, break flag.
// Assumes it is bound to arpwm_timer and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
`include "arpwm_cfg.svh"
module arpwm_timer_chk (
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       captureInput,
    input wire logic [3:0] waveOutEn,
    input wire logic       compareIrq,
    input wire logic       captureIrq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    logic       capPrev_r;  // Capture input one edge ago
    logic [3:0] age_r;      // Cycles since it moved, saturating
    logic [3:0] age_nxt;

    // Age restarts on any move; saturation keeps it from wrapping into range
    always_comb
    begin
        if (captureInput != capPrev_r)
            age_nxt = 4'h0;
        else if (age_r != 4'hF)
            age_nxt = age_r + 4'h1;
        else
            age_nxt = age_r;
    end

    // Helper registers
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            capPrev_r <= 1'b0;
            age_r     <= 4'hF;
        end
        else
        begin
            capPrev_r <= captureInput;
            age_r     <= age_nxt;
        end
    end

    sequence s_brk_set; wr && addr == `OFS_BRKCTL && wdata[7]; endsequence
    sequence s_brk_clr; wr && addr == `OFS_BRKCTL && wdata[7:4] == 4'h0; endsequence
    sequence s_brk_rd; rd && addr == `OFS_BRKCTL; endsequence

    property p_oe_follow; wr && addr == `OFS_OUTCTL |=> waveOutEn == $past(wdata[3:0]);
    endproperty
    property p_oe_hold; !(wr && addr == `OFS_OUTCTL) |=> $stable(waveOutEn); endproperty
    property p_cmp_off; wr && addr == `OFS_CTRL && !wdata[`CTRL_COMPARE_IRQ_ENABLE] |=> !compareIrq;
    endproperty
    property p_cap_lat; $rose(captureIrq) && !$past(wr) |-> age_r inside {[4'h1:4'hA]};
    endproperty
    property p_cap_clr;
        rd && (addr == `OFS_CAP_L || addr == `OFS_CAP_H) && captureIrq |=> !captureIrq;
    endproperty
    property p_cap_hold; captureIrq && !rd && !wr |=> captureIrq; endproperty
    property p_sw_break; s_brk_set ##[1:3] s_brk_rd |=> rdata[7]; endproperty
    property p_sw_clear; s_brk_clr ##[1:3] s_brk_rd |=> !rdata[7]; endproperty

    a_oe_follow: assert property (p_oe_follow) else $error("enables not loaded");
    a_oe_hold: assert property (p_oe_hold) else $error("enables moved");
    a_cmp_off: assert property (p_cmp_off) else $error("compare irq unmasked");
    a_cap_lat: assert property (p_cap_lat) else $error("capture irq timing");
    a_cap_clr: assert property (p_cap_clr) else $error("capture flag kept");
    a_cap_hold: assert property (p_cap_hold) else $error("capture flag lost");
    a_sw_break: assert property (p_sw_break) else $error("break flag not set");
    a_sw_clear: assert property (p_sw_clear) else $error("break flag not cleared");
endmodule : arpwm_timer_chk

bind arpwm_timer arpwm_timer_chk u_chk (
    .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .captureInput(captureInput), .waveOutEn(waveOutEn),
    .compareIrq(compareIrq), .captureIrq(captureIrq)
);
`default_nettype wire

// [tb_arpwm_timer.sv]
// Self-checking bench for the autoreload PWM timer, driven over its strobe register port.
// Assumes the checker is bound in and the power stage model drives break and capture.
`timescale 1ns/10ps
`default_nettype none
`include "arpwm_cfg.svh"
module tb_arpwm_timer;
    logic       ref_clk;
    logic       resetn;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       brkPin;
    logic       captureInput;
    logic [3:0] waveOut;
    logic [3:0] waveOutEn;
    logic       compareIrq;
    logic       captureIrq;
    int         n_errors = 0;
    int         checks_done = 0;
    int         cycles = 0;    // Timeout count
    int         i;
    logic [7:0] d;             // Last read data
    logic [7:0] dutyHi [4] = '{8'h0F, 8'h00, 8'h0F, 8'h0F};
    logic [7:0] dutyLo [4] = '{8'hF8, 8'h00, 8'hFC, 8'hF4};  // Channel 1 stays zero

    arpwm_timer dut (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .brkPin(brkPin), .captureInput(captureInput),
        .waveOut(waveOut), .waveOutEn(waveOutEn), .compareIrq(compareIrq),
        .captureIrq(captureIrq));
    power_stage_model stage (.ref_clk(ref_clk), .brkPin(brkPin), .captureInput(captureInput));

    // 125 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    // Cuts a hang short; the run needs about 14000 cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_count(input int got, input int exp);
        checks_done++;
        if (got != exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_count

    // One-cycle write strobe
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data is only valid in the cycle after the strobe
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
        chk_byte(d & m, e);
    endtask : rd_chk

    task automatic wait_lvl(input int ch, input logic lvl);
        for (int k = 0; k < 5000 && waveOut[ch] !== lvl; k++)
            tick();
    endtask : wait_lvl

    // High time and period of one output, counted from a rising edge
    task automatic pwm_chk(input int ch, input int eh, input int ep);
        int h;
        int p;
        wait_lvl(ch, 1'b0);
        wait_lvl(ch, 1'b1);
        for (h = 0; waveOut[ch] === 1'b1 && h < 5000; h++)
            tick();
        for (p = h; waveOut[ch] !== 1'b1 && p < 5000; p++)
            tick();
        chk_count(h, eh);
        chk_count(p, ep);
    endtask : pwm_chk

    initial
    begin
        resetn = 1'b0;
        addr = 5'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        rd_chk(`OFS_CTRL, 8'hFF, 8'h06);
        rd_chk(`OFS_OUTCTL, 8'hFF, 8'h00);
        rd_chk(5'h1F, 8'hFF, 8'h00);
        $display("reset test done");
        wr_reg(`OFS_RELOAD1_L, 8'hF0);
        wr_reg(`OFS_RELOAD1_H, 8'h0F);
        for (i = 0; i < 4; i++)
        begin
            wr_reg(`OFS_DUTY_BASE + 5'(2 * i), dutyHi[i]);
            wr_reg(`OFS_DUTY_BASE + 5'(2 * i + 1), dutyLo[i]);
        end
        wr_reg(`OFS_OUTCTL, 8'h0F);
        wr_reg(`OFS_CTRL, 8'h0E);
        repeat (4300) @(posedge ref_clk);  // First overflow comes from zero
        pwm_chk(0, 9, 16);
        pwm_chk(2, 13, 16);
        pwm_chk(3, 5, 16);
        $display("period test done");
        wr_reg(`OFS_OUTCTL, 8'h8F);
        repeat (40) @(posedge ref_clk);
        pwm_chk(3, 11, 16);
        $display("polarity test done");
        rd_chk(`OFS_STATUS, 8'h0F, 8'h0D);
        chk_byte({7'h00, compareIrq}, 8'h01);
        $display("compare test done");
        wr_reg(`OFS_RELOAD2_L, 8'hF8);
        wr_reg(`OFS_RELOAD2_H, 8'h0F);
        wr_reg(`OFS_CTRL, 8'h0F);
        repeat (4300) @(posedge ref_clk);
        pwm_chk(2, 5, 8);
        pwm_chk(0, 9, 16);
        wr_reg(`OFS_CTRL, 8'h0B);
        wr_reg(`OFS_DUTY_BASE + 5'h05, 8'hFE);
        repeat (40) @(posedge ref_clk);
        pwm_chk(2, 5, 8);
        wr_reg(`OFS_CTRL, 8'h0F);
        repeat (20) @(posedge ref_clk);
        pwm_chk(2, 7, 8);
        $display("dual test done");
        wr_reg(`OFS_DEADTIME, 8'h82);
        repeat (40) @(posedge ref_clk);
        pwm_chk(0, 7, 16);
        pwm_chk(1, 5, 16);
        wr_reg(`OFS_DEADTIME, 8'h80);
        repeat (40) @(posedge ref_clk);
        repeat (16)
        begin
            tick();
            chk_byte({6'h00, waveOut[1:0]}, 8'h00);
        end
        wr_reg(`OFS_DEADTIME, 8'h00);
        $display("dead time test done");
        wr_reg(`OFS_CTRL, 8'h1F);
        stage.flip_capture(3);
        for (i = 0; i < 20 && captureIrq !== 1'b1; i++)
            tick();
        chk_byte({7'h00, captureIrq}, 8'h01);
        rd_chk(`OFS_STATUS, 8'h10, 8'h10);
        rd_chk(`OFS_CAP_H, 8'h0F, 8'h0F);
        rd_chk(`OFS_STATUS, 8'h10, 8'h00);
        $display("capture test done");
        wr_reg(`OFS_BRKEN, 8'h03);
        wr_reg(`OFS_BRKCTL, 8'h85);
        tick();
        chk_byte({4'h0, waveOut}, 8'h05);
        rd_chk(`OFS_BRKCTL, 8'h80, 8'h80);
        wr_reg(`OFS_BRKCTL, 8'h00);
        rd_chk(`OFS_BRKCTL, 8'h80, 8'h00);
        $display("software break test done");
        wr_reg(`OFS_BRKCTL, 8'h7A);
        stage.trip(1'b1, 2);
        repeat (8) tick();
        rd_chk(`OFS_BRKCTL, 8'h80, 8'h80);
        chk_byte({4'h0, waveOut}, 8'h0A);
        stage.trip(1'b0, 1);
        repeat (8) tick();
        wr_reg(`OFS_BRKCTL, 8'h00);
        rd_chk(`OFS_BRKCTL, 8'h80, 8'h00);
        wr_reg(`OFS_STATUS, 8'h0F);
        repeat (4200) @(posedge ref_clk);  // Old duties would match within this span
        rd_chk(`OFS_STATUS, 8'h0F, 8'h00);
        wr_reg(`OFS_CTRL, 8'h07);
        tick();
        chk_byte({7'h00, compareIrq}, 8'h00);
        $display("pin break test done");
        tally_and_finish();
    end
endmodule : tb_arpwm_timer
`default_nettype wire
